// file: hdl/sca_pkg.sv
// constants for the serial clock mode and slot assigner block
// Function
// - mode 3a: pin-fed generator, 16x recovery reference
// - mode 3b: generator output clocks both directions
// - mode 4: separate clocks, per-bit gate inputs
// - mode 5a: one pin clock, slots after frame sync
// - single slot, width 1 to 512, programmable position
// - or up to 32 masked 8-bit slots
// - independent directions, delay 1 to 1024 clocks
// - 5a with output enable: pin low in tx window
// - sync loads offset 1024-delay; 1024 starts duration
// - continuous: offset wraps to 0, sync restarts
// - non-continuous: offset halts at 1024 until sync
// - duration counter always runs to completion
// - mask enabled: width field ignored, 8-bit slots
// - mode 5b: masks forced, width fields ignored
// - mode 5b: own clocks, own octet syncs per direction
// - mode 5b: octets aligned to slot boundaries
// - mode 6: crystal generator; rx div16, tx 6a pin, 6b div16
// - mode 7: crystal generator; 7a recovered, 7b direct
package sca_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CFG_LOW = 8'h00;
  localparam logic [7:0] OFS_CFG_HIGH = 8'h04;
  localparam logic [7:0] OFS_TX_SLOT = 8'h08;
  localparam logic [7:0] OFS_RX_SLOT = 8'h0c;
  localparam logic [7:0] OFS_TX_MASK = 8'h10;
  localparam logic [7:0] OFS_RX_MASK = 8'h14;
  localparam logic [7:0] OFS_RATE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // channel_config_low fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SSEL_BIT = 3;
  localparam int CFG_TOE_BIT = 4;
  // channel_config_high field
  localparam int CFG_SCM_BIT = 0;
  // slot assign fields
  localparam int SA_CS_LSB = 0;
  localparam int SA_TSN_LSB = 3;
  localparam int SA_CC_LSB = 16;
  localparam int SA_MEN_BIT = 31;
  // reset values
  localparam logic [31:0] RST_CFG_LOW = 32'h0000_0000;
  localparam logic [31:0] RST_CFG_HIGH = 32'h0000_0000;
  localparam logic [31:0] RST_SLOT = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [15:0] RST_RATE = 16'h0000;
  // clock mode numbers
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;
  // slot assigner counts
  localparam logic [10:0] OFF_MAX = 11'h400;
  localparam logic [9:0] OCTET_FRAME_LEN = 10'h100;
  localparam logic [3:0] REC_DIV_LAST = 4'hf;
endpackage

// file: hdl/sca_slot_assigner.sv
// one direction of the time slot assigner: offset and duration counters
`timescale 1ns/10ps
`default_nettype none
module sca_slot_assigner (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // bit clock and sync event
  input wire logic tick_i,
  input wire logic sync_i,
  // configuration
  input wire logic cont_i,
  input wire logic mask_en_i,
  input wire logic [10:0] delay_i,
  input wire logic [9:0] width_i,
  input wire logic [31:0] mask_i,
  // slot state
  output logic active_o,
  output logic octet_o
);
  logic [10:0] off_q;
  logic run_q;
  logic [9:0] pos_q;
  logic [9:0] len_q;
  logic hit;

  assign hit = tick_i && !sync_i && (off_q == sca_pkg::OFF_MAX - 11'h001);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_q <= sca_pkg::OFF_MAX;
    end else if (tick_i) begin
      if (sync_i) begin
        off_q <= sca_pkg::OFF_MAX - delay_i;
      end else if (off_q != sca_pkg::OFF_MAX) begin
        off_q <= off_q + 11'h001;
      end else if (cont_i) begin
        off_q <= 11'h000;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      pos_q <= 10'h000;
      len_q <= 10'h000;
    end else if (tick_i) begin
      if (run_q) begin
        if (pos_q == len_q - 10'h001) begin
          run_q <= 1'b0;
        end
        pos_q <= pos_q + 10'h001;
      end else if (hit) begin
        run_q <= 1'b1;
        pos_q <= 10'h000;
        len_q <= mask_en_i ? sca_pkg::OCTET_FRAME_LEN : width_i;
      end
    end
  end

  assign active_o = run_q && (!mask_en_i || mask_i[pos_q[7:3]]);
  assign octet_o = tick_i && active_o && (pos_q[2:0] == 3'h0);

  AST_OFFSET_RELOAD: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) tick_i && sync_i
    |=> off_q == sca_pkg::OFF_MAX - $past(delay_i))
    else $error("offset not reloaded from delay");
  AST_OFFSET_WRAP: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    tick_i && !sync_i && cont_i && off_q == sca_pkg::OFF_MAX
    |=> off_q == 11'h000)
    else $error("offset did not wrap in continuous mode");
  AST_OFFSET_HALT: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    !cont_i && off_q == sca_pkg::OFF_MAX && !(tick_i && sync_i)
    |=> off_q == sca_pkg::OFF_MAX)
    else $error("offset left maximum without sync");
  AST_RUN_THROUGH_SYNC: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    run_q && tick_i && sync_i && pos_q != len_q - 10'h001 |=> run_q)
    else $error("active slot cut by sync");
  AST_SLOT_WIDTH: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) hit && !run_q && !mask_en_i
    |=> run_q && len_q == $past(width_i) && pos_q == 10'h000)
    else $error("single slot width wrong");
  AST_MASK_LEN: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) hit && !run_q && mask_en_i
    |=> len_q == sca_pkg::OCTET_FRAME_LEN)
    else $error("mask mode length not 256");
endmodule
`default_nettype wire

// file: hdl/sca_clock_slot.sv
// clock source selection, per-bit gating and slot assigner for one channel
`timescale 1ns/10ps
`default_nettype none
module sca_clock_slot (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // line pins
  input wire logic receive_clock_pin_i,
  input wire logic transmit_clock_pin_i,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe_o,
  input wire logic crystal_input_i,
  input wire logic frame_sync_in_i,
  input wire logic rx_octet_sync_i,
  input wire logic tx_octet_sync_i,
  input wire logic rx_gate_in_i,
  input wire logic tx_gate_in_i,
  // effective bit clocks to the serial channel
  output logic rx_clk_en_o,
  output logic tx_clk_en_o,
  output logic rx_slot_active_o,
  output logic tx_slot_active_o,
  output logic rx_octet_start_o,
  output logic tx_octet_start_o
);
  localparam int NPIN = 8;

  // configuration registers
  logic [31:0] cfg_low_q;
  logic [31:0] cfg_high_q;
  logic [31:0] tx_slot_assign_regs_q;
  logic [31:0] rx_slot_assign_regs_q;
  logic [31:0] tx_slot_mask_q;
  logic [31:0] rx_slot_mask_q;
  logic [15:0] rate_div_q;
  logic [31:0] rdata_q;

  // pin synchronisers and edge state
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_s_q;
  logic [NPIN-1:0] pin_p_q;
  logic rxc_tick;
  logic txc_tick;
  logic xtal_tick;
  logic fsync_s;
  logic rosync_s;
  logic tosync_s;
  logic rgate_s;
  logic tgate_s;

  // rate generator and recovery
  logic [15:0] rate_cnt_q;
  logic [3:0] rec_cnt_q;
  logic gen_src;
  logic gen_tick;
  logic rec_tick;

  // mode decode
  logic [2:0] clock_mode_field;
  logic ssel;
  logic tx_clock_output_enable;
  logic slot_counter_mode;
  logic m3;
  logic m4;
  logic m5a;
  logic m5b;
  logic m6;
  logic m7;

  // per-direction slot clocks and sync
  logic rx_bit;
  logic tx_bit;
  logic rx_sync_lvl;
  logic tx_sync_lvl;
  logic rx_sync_prev_q;
  logic tx_sync_prev_q;
  logic rx_sync_ev;
  logic tx_sync_ev;
  logic rx_mask_enable;
  logic tx_mask_enable;
  logic [10:0] rx_delay;
  logic [10:0] tx_delay;
  logic [9:0] rx_slot_width;
  logic [9:0] tx_slot_width;
  logic rx_act;
  logic tx_act;
  logic rx_oct;
  logic tx_oct;
  logic tx_eff;

  // register writes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_low_q <= sca_pkg::RST_CFG_LOW;
      cfg_high_q <= sca_pkg::RST_CFG_HIGH;
      tx_slot_assign_regs_q <= sca_pkg::RST_SLOT;
      rx_slot_assign_regs_q <= sca_pkg::RST_SLOT;
      tx_slot_mask_q <= sca_pkg::RST_MASK;
      rx_slot_mask_q <= sca_pkg::RST_MASK;
      rate_div_q <= sca_pkg::RST_RATE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        sca_pkg::OFS_CFG_LOW: cfg_low_q <= {27'h0, reg_wdata_i[4:0]};
        sca_pkg::OFS_CFG_HIGH: cfg_high_q <= {31'h0, reg_wdata_i[0]};
        sca_pkg::OFS_TX_SLOT: tx_slot_assign_regs_q <= reg_wdata_i;
        sca_pkg::OFS_RX_SLOT: rx_slot_assign_regs_q <= reg_wdata_i;
        sca_pkg::OFS_TX_MASK: tx_slot_mask_q <= reg_wdata_i;
        sca_pkg::OFS_RX_MASK: rx_slot_mask_q <= reg_wdata_i;
        sca_pkg::OFS_RATE: rate_div_q <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        sca_pkg::OFS_CFG_LOW: rdata_q <= cfg_low_q;
        sca_pkg::OFS_CFG_HIGH: rdata_q <= cfg_high_q;
        sca_pkg::OFS_TX_SLOT: rdata_q <= tx_slot_assign_regs_q;
        sca_pkg::OFS_RX_SLOT: rdata_q <= rx_slot_assign_regs_q;
        sca_pkg::OFS_TX_MASK: rdata_q <= tx_slot_mask_q;
        sca_pkg::OFS_RX_MASK: rdata_q <= rx_slot_mask_q;
        sca_pkg::OFS_RATE: rdata_q <= {16'h0, rate_div_q};
        sca_pkg::OFS_STATUS: rdata_q <= {30'h0, tx_act, rx_act};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata_o = rdata_q;

  // field views
  assign clock_mode_field = cfg_low_q[sca_pkg::CFG_MODE_LSB +: 3];
  assign ssel = cfg_low_q[sca_pkg::CFG_SSEL_BIT];
  assign tx_clock_output_enable = cfg_low_q[sca_pkg::CFG_TOE_BIT];
  assign slot_counter_mode = cfg_high_q[sca_pkg::CFG_SCM_BIT];
  assign m3 = clock_mode_field == sca_pkg::MODE_3;
  assign m4 = clock_mode_field == sca_pkg::MODE_4;
  assign m5a = clock_mode_field == sca_pkg::MODE_5 && !ssel;
  assign m5b = clock_mode_field == sca_pkg::MODE_5 && ssel;
  assign m6 = clock_mode_field == sca_pkg::MODE_6;
  assign m7 = clock_mode_field == sca_pkg::MODE_7;

  // all pins come from outside: two flops, then a third for edges
  assign pin_raw = {tx_gate_in_i, rx_gate_in_i, tx_octet_sync_i,
                    rx_octet_sync_i, frame_sync_in_i, crystal_input_i,
                    transmit_clock_pin_i, receive_clock_pin_i};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_m_q[gi] <= 1'b0;
          pin_s_q[gi] <= 1'b0;
          pin_p_q[gi] <= 1'b0;
        end else begin
          pin_m_q[gi] <= pin_raw[gi];
          pin_s_q[gi] <= pin_m_q[gi];
          pin_p_q[gi] <= pin_s_q[gi];
        end
      end
    end
  endgenerate
  // rising edges of the pin clocks act as bit ticks
  assign rxc_tick = pin_s_q[0] && !pin_p_q[0];
  assign txc_tick = pin_s_q[1] && !pin_p_q[1];
  assign xtal_tick = pin_s_q[2] && !pin_p_q[2];
  assign fsync_s = pin_s_q[3];
  assign rosync_s = pin_s_q[4];
  assign tosync_s = pin_s_q[5];
  assign rgate_s = pin_s_q[6];
  assign tgate_s = pin_s_q[7];

  // crystal feeds generator in 6 and 7
  assign gen_src = (m6 || m7) ? xtal_tick : (m3 ? rxc_tick : 1'b0);

  // plain divide by (rate_div+1); finer division lies elsewhere
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_cnt_q <= 16'h0000;
    end else if (gen_src) begin
      if (rate_cnt_q >= rate_div_q) begin
        rate_cnt_q <= 16'h0000;
      end else begin
        rate_cnt_q <= rate_cnt_q + 16'h0001;
      end
    end
  end
  assign gen_tick = gen_src && (rate_cnt_q >= rate_div_q);

  // recovered clock is generator over 16
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rec_cnt_q <= 4'h0;
    end else if (gen_tick) begin
      rec_cnt_q <= rec_cnt_q + 4'h1;
    end
  end
  assign rec_tick = gen_tick && (rec_cnt_q == sca_pkg::REC_DIV_LAST);

  // per-direction bit clocks before gating
  always_comb begin
    rx_bit = 1'b0;
    tx_bit = 1'b0;
    if (m3 || m7) begin
      // 3b and 7b use generator directly
      rx_bit = ssel ? gen_tick : rec_tick;
      tx_bit = ssel ? gen_tick : rec_tick;
    end else if (m4) begin
      rx_bit = rxc_tick;
      tx_bit = txc_tick;
    end else if (m5a) begin
      rx_bit = rxc_tick;
      tx_bit = rxc_tick;
    end else if (m5b) begin
      rx_bit = rxc_tick;
      tx_bit = txc_tick;
    end else if (m6) begin
      // rx generator over 16; tx 6a pin, 6b generator over 16
      rx_bit = rec_tick;
      tx_bit = ssel ? rec_tick : txc_tick;
    end
  end

  // octet syncs per direction in 5b
  assign rx_sync_lvl = m5b ? rosync_s : fsync_s;
  assign tx_sync_lvl = m5b ? tosync_s : fsync_s;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sync_prev_q <= 1'b0;
      tx_sync_prev_q <= 1'b0;
    end else begin
      if (rx_bit) begin
        rx_sync_prev_q <= rx_sync_lvl;
      end
      if (tx_bit) begin
        tx_sync_prev_q <= tx_sync_lvl;
      end
    end
  end
  assign rx_sync_ev = rx_bit && rx_sync_lvl && !rx_sync_prev_q;
  assign tx_sync_ev = tx_bit && tx_sync_lvl && !tx_sync_prev_q;

  // delay 1 + number*8 + shift
  assign tx_delay = 11'h001 + {1'b0, tx_slot_assign_regs_q[9:3], 3'h0}
                    + {8'h00, tx_slot_assign_regs_q[2:0]};
  assign rx_delay = 11'h001 + {1'b0, rx_slot_assign_regs_q[9:3], 3'h0}
                    + {8'h00, rx_slot_assign_regs_q[2:0]};
  assign tx_slot_width = {1'b0, tx_slot_assign_regs_q[24:16]} + 10'h001;
  assign rx_slot_width = {1'b0, rx_slot_assign_regs_q[24:16]} + 10'h001;
  assign tx_mask_enable = tx_slot_assign_regs_q[sca_pkg::SA_MEN_BIT] || m5b;
  assign rx_mask_enable = rx_slot_assign_regs_q[sca_pkg::SA_MEN_BIT] || m5b;

  sca_slot_assigner u_rx_slot (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(rx_bit && (m5a || m5b)),
    .sync_i(rx_sync_ev),
    .cont_i(!slot_counter_mode),
    .mask_en_i(rx_mask_enable),
    .delay_i(rx_delay),
    .width_i(rx_slot_width),
    .mask_i(rx_slot_mask_q),
    .active_o(rx_act),
    .octet_o(rx_oct)
  );

  sca_slot_assigner u_tx_slot (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tx_bit && (m5a || m5b)),
    .sync_i(tx_sync_ev),
    .cont_i(!slot_counter_mode),
    .mask_en_i(tx_mask_enable),
    .delay_i(tx_delay),
    .width_i(tx_slot_width),
    .mask_i(tx_slot_mask_q),
    .active_o(tx_act),
    .octet_o(tx_oct)
  );

  // slot modes gate clocks with slots
  // mode 4 gates clocks per bit
  assign rx_clk_en_o = rx_bit && (m4 ? rgate_s
                                : ((m5a || m5b) ? rx_act : 1'b1));
  assign tx_eff = tx_bit && (m4 ? tgate_s
                           : ((m5a || m5b) ? tx_act : 1'b1));
  assign tx_clk_en_o = tx_eff;
  assign rx_slot_active_o = rx_act && (m5a || m5b);
  assign tx_slot_active_o = tx_act && (m5a || m5b);
  assign rx_octet_start_o = rx_oct && m5b;
  assign tx_octet_start_o = tx_oct && m5b;

  // transmit pin driver; a pin that is an input stays released
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transmit_clock_pin_o <= 1'b1;
      transmit_clock_pin_oe_o <= 1'b0;
    end else if (m5a && tx_clock_output_enable) begin
      transmit_clock_pin_o <= !tx_act;
      transmit_clock_pin_oe_o <= 1'b1;
    end else if (tx_clock_output_enable
                 && (m3 || m7 || (m6 && ssel))) begin
      // monitor image: one high sample per transmit bit
      transmit_clock_pin_o <= tx_bit;
      transmit_clock_pin_oe_o <= 1'b1;
    end else begin
      transmit_clock_pin_o <= 1'b1;
      transmit_clock_pin_oe_o <= 1'b0;
    end
  end

  AST_TX_WINDOW_PIN: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) m5a && tx_clock_output_enable && tx_act
    |=> transmit_clock_pin_oe_o && !transmit_clock_pin_o)
    else $error("transmit window not shown low on pin");
  AST_RX_ONLY_IN_SLOT: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) m5a && rx_clk_en_o |-> rx_slot_active_o)
    else $error("receive clock outside slot");
  AST_MODE4_GATE: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) m4 && !tgate_s |-> !tx_clk_en_o)
    else $error("transmit bit passed closed gate");
  AST_MODE3B_DIRECT: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i) m3 && ssel
    |-> rx_clk_en_o == gen_tick && tx_clk_en_o == gen_tick)
    else $error("mode 3b clocks not from generator");
endmodule
`default_nettype wire

// file: tb/sca_line_model.sv
// line side model: free bit clocks, crystal, sync pulses, tx pin wire
`timescale 1ns/10ps
`default_nettype none
module sca_line_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // sync requests: bit0 frame, bit1 rx octet, bit2 tx octet
  input wire logic [2:0] sync_req_i,
  // transmit clock pin, device side
  input wire logic tx_pin_i,
  input wire logic tx_pin_oe_i,
  // line pins
  output logic line_clk_o,
  output logic tx_wire_o,
  output logic crystal_o,
  output logic [2:0] sync_o,
  output logic tick_o
);
  logic [2:0] ph_q;
  logic [2:0] pend_q;
  // one bit every 8 system cycles, so a synced edge lands well inside it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= 3'h0;
      line_clk_o <= 1'b0;
    end else begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) line_clk_o <= 1'b1;
      if (ph_q == 3'h3) line_clk_o <= 1'b0;
    end
  end
  // syncs move on the falling clock and last one bit: one sampling edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= 3'h0;
      sync_o <= 3'h0;
    end else if (ph_q == 3'h3) begin
      sync_o <= pend_q;
      pend_q <= sync_req_i;
    end else begin
      pend_q <= pend_q | sync_req_i;
    end
  end
  assign tick_o = line_clk_o && (ph_q == 3'h0);
  assign tx_wire_o = tx_pin_oe_i ? tx_pin_i : line_clk_o;
  // clocks only, no line coding here
  assign crystal_o = ~line_clk_o;
endmodule
`default_nettype wire

// file: tb/tb_serial_clock_mode_slot_assigner.sv
// self-checking bench for the clock mode and slot assigner
`timescale 1ns/10ps
`default_nettype none
module tb_serial_clock_mode_slot_assigner;
  logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic rxp, txw, txo, txoe, xtal, rxg, txg, tick, pa;
  logic rxe, txe, rxa, txa, rxos, txos;
  logic [2:0] sy, req;
  int error_cnt, n_tests, rc, tc, rf, tf, ro, tm, ra, tos;

  sca_clock_slot dut (
    .sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o,
    .receive_clock_pin_i(rxp), .transmit_clock_pin_i(txw),
    .transmit_clock_pin_o(txo), .transmit_clock_pin_oe_o(txoe),
    .crystal_input_i(xtal), .frame_sync_in_i(sy[0]),
    .rx_octet_sync_i(sy[1]), .tx_octet_sync_i(sy[2]),
    .rx_gate_in_i(rxg), .tx_gate_in_i(txg),
    .rx_clk_en_o(rxe), .tx_clk_en_o(txe),
    .rx_slot_active_o(rxa), .tx_slot_active_o(txa),
    .rx_octet_start_o(rxos), .tx_octet_start_o(txos)
  );
  sca_line_model line (
    .sys_clk_i, .rst_n_i, .sync_req_i(req), .tx_pin_i(txo),
    .tx_pin_oe_i(txoe), .line_clk_o(rxp), .tx_wire_o(txw),
    .crystal_o(xtal), .sync_o(sy), .tick_o(tick)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask

  function automatic logic [31:0] in2(int v, int a);
    return 32'(v == a || v == a + 1);
  endfunction

  // exact for fast clocks, one off allowed for the slow recovered ones
  function automatic logic [31:0] near(int v, int e);
    return 32'((v - e) ** 2 <= int'(e < 16));
  endfunction

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // data stand one cycle only, then drop back to zero
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("rdata", e, reg_rdata_o);
    @(posedge sys_clk_i);
    #1 chk("rdata idle", 32'h0, reg_rdata_o);
  endtask

  function automatic logic [31:0] sa(int n, int s, int w, int m);
    return 32'(s) | 32'(n) << sca_pkg::SA_TSN_LSB
      | 32'(w - 1) << sca_pkg::SA_CC_LSB | 32'(m) << sca_pkg::SA_MEN_BIT;
  endfunction

  task automatic cfg(logic [2:0] md, int ss, int oe, int scm);
    wr(sca_pkg::OFS_CFG_LOW, 32'(md) | 32'(ss) << sca_pkg::CFG_SSEL_BIT
       | 32'(oe) << sca_pkg::CFG_TOE_BIT);
    wr(sca_pkg::OFS_CFG_HIGH, 32'(scm));
  endtask

  task automatic slots(logic [31:0] r, logic [31:0] t);
    wr(sca_pkg::OFS_RX_SLOT, r);
    wr(sca_pkg::OFS_TX_SLOT, t);
  endtask

  // counts enables over n line ticks from the sync tick; resync at tick ag
  task automatic run(logic [2:0] s, int n, int ag);
    int k;
    int t;
    rc = 0;
    tc = 0;
    rf = -1;
    tf = -1;
    ro = 0;
    tm = 0;
    ra = 0;
    tos = 0;
    k = 0;
    t = 0;
    @(posedge sys_clk_i);
    req <= s;
    @(posedge sys_clk_i);
    req <= 3'h0;
    while (!(tick && (sy & s) != 3'h0)) begin
      @(posedge sys_clk_i);
      #1 t++;
      if (t > 40) begin
        error_cnt++;
        report_and_stop();
      end
    end
    pa = txa;
    t = 0;
    while (k < n) begin
      @(posedge sys_clk_i);
      #1 if (tick) k++;
      t++;
      // a stalled line clock must not hang the run
      if (t > 8 * n + 16) begin
        error_cnt++;
        report_and_stop();
      end
      req <= (tick && k == ag) ? s : 3'h0;
      if (rxe === 1'b1 && rf < 0) rf = k;
      if (txe === 1'b1 && tf < 0) tf = k;
      rc += int'(rxe === 1'b1);
      tc += int'(txe === 1'b1);
      ro += int'(rxos === 1'b1);
      tos += int'(txos === 1'b1);
      ra += int'(rxa === 1'b1);
      if (txoe !== 1'b1 || txo !== !pa) tm++;
      pa = txa;
    end
  endtask

  task automatic s_regs();
    logic [31:0] rv[8] = '{sca_pkg::RST_CFG_LOW, sca_pkg::RST_CFG_HIGH,
      sca_pkg::RST_SLOT, sca_pkg::RST_SLOT, sca_pkg::RST_MASK,
      sca_pkg::RST_MASK, 32'(sca_pkg::RST_RATE), 32'h0};
    for (int i = 0; i < 8; i++) rd(8'(4 * i), rv[i]);
    rd(8'h20, 32'h0);
    wr(sca_pkg::OFS_RATE, 32'hffff_0000);
    rd(sca_pkg::OFS_RATE, 32'h0);
    wr(sca_pkg::OFS_RX_MASK, 32'h8000_0001);
    rd(sca_pkg::OFS_RX_MASK, 32'h8000_0001);
  endtask

  task automatic s_5a();
    cfg(sca_pkg::MODE_5, 0, 1, 1);
    // tx width kept a multiple of 8
    slots(sa(1, 2, 5, 0), sa(0, 5, 8, 0));
    run(3'h1, 30, -1);
    chk("rx width", 32'h5, 32'(rc));
    chk("tx width", 32'h8, 32'(tc));
    chk("rx start", 32'h1, in2(rf, 11));
    chk("tx start", 32'h1, in2(tf, 6));
    chk("tx pin status", 32'h0, 32'(tm));
    // five bits of eight system cycles each
    chk("rx window", 32'h28, 32'(ra));
    chk("no octet marks", 32'h0, 32'(ro));
  endtask

  task automatic s_mask();
    cfg(sca_pkg::MODE_5, 0, 0, 1);
    slots(sa(0, 0, 3, 1), sa(0, 0, 3, 1));
    wr(sca_pkg::OFS_RX_MASK, 32'h0000_0005);
    wr(sca_pkg::OFS_TX_MASK, 32'h8000_0000);
    run(3'h1, 270, -1);
    chk("rx mask bits", 32'h10, 32'(rc));
    chk("tx mask bits", 32'h8, 32'(tc));
    chk("rx mask start", 32'h1, in2(rf, 1));
    chk("tx slot 31", 32'h1, in2(tf, 249));
  endtask

  task automatic s_cont();
    for (int m = 0; m < 2; m++) begin
      cfg(sca_pkg::MODE_5, 0, 0, m);
      // delay spans the whole 1024 frame
      slots(sa(127, 7, 1, 0), sa(0, 0, 2, 0));
      run(3'h1, 1040, -1);
      chk("rx far slot", 32'h1, 32'(rc));
      chk("rx far start", 32'h1, in2(rf, 1024));
      chk("tx repeat", m ? 32'h2 : 32'h4, 32'(tc));
    end
  endtask

  task automatic s_overlap();
    cfg(sca_pkg::MODE_5, 0, 0, 1);
    slots(sa(0, 0, 10, 0), sa(0, 0, 2, 0));
    run(3'h1, 30, 5);
    chk("rx no cut", 32'ha, 32'(rc));
  endtask

  task automatic s_5b();
    cfg(sca_pkg::MODE_5, 1, 0, 1);
    // both mask enables set by software
    slots(sa(0, 0, 1, 1), sa(0, 0, 1, 1));
    wr(sca_pkg::OFS_RX_MASK, 32'h1);
    wr(sca_pkg::OFS_TX_MASK, 32'h1);
    run(3'h2, 20, -1);
    chk("rx octet", 32'h8, 32'(rc));
    chk("tx untouched", 32'h0, 32'(tc));
    chk("octet start", 32'h1, 32'(ro));
    run(3'h4, 20, -1);
    chk("tx octet", 32'h8, 32'(tc));
    chk("rx untouched", 32'h0, 32'(rc));
    chk("tx octet start", 32'h1, 32'(tos));
  endtask

  task automatic s_mode4();
    cfg(sca_pkg::MODE_4, 0, 0, 1);
    for (int g = 0; g < 2; g++) begin
      @(posedge sys_clk_i);
      rxg <= g[0];
      txg <= !g[0];
      run(3'h1, 16, -1);
      chk("rx gated", g ? 32'h10 : 32'h0, 32'(rc));
      chk("tx gated", g ? 32'h0 : 32'h10, 32'(tc));
    end
  endtask

  task automatic s_clk();
    int e[6][4] = '{'{3, 0, 4, 4}, '{3, 1, 64, 64}, '{6, 0, 4, 64},
                    '{6, 1, 4, 4}, '{7, 0, 4, 4}, '{7, 1, 64, 64}};
    for (int i = 0; i < 6; i++) begin
      cfg(3'(e[i][0]), e[i][1], 0, 1);
      run(3'h1, 64, -1);
      chk("rx rate", 32'h1, near(rc, e[i][2]));
      chk("tx rate", 32'h1, near(tc, e[i][3]));
    end
  endtask

  initial begin
    rst_n_i = 1'b0;
    reg_addr_i = 8'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rxg = 1'b1;
    txg = 1'b1;
    req = 3'h0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    s_regs();
    s_5a();
    s_mask();
    s_cont();
    s_overlap();
    s_5b();
    s_mode4();
    s_clk();
    report_and_stop();
  end
endmodule
`default_nettype wire
